// ==== logic/fllr_pkg.sv ====
// Constants for the fault record loop readout formatter
package fllr_pkg;
  localparam int unsigned LOOP_LEN = 36;
  localparam int unsigned POS_W = 6;
  localparam int unsigned IDX_W = 8;
  localparam logic [7:0] BYTE_COUNT = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [IDX_W-1:0] IDX_PTR = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RSVD = 8'h01;
  localparam logic [IDX_W-1:0] IDX_LOOP_FIRST = 8'h37;
  localparam logic [IDX_W-1:0] IDX_LOOP_LAST = 8'hed;
  localparam logic [IDX_W-1:0] IDX_LAST = 8'hfe;
  localparam logic [IDX_W-1:0] IDX_END = 8'hff;
  localparam logic [POS_W-1:0] POS_TOP = 6'h23;
  localparam logic [POS_W-1:0] POS_BOTTOM = 6'h00;
  localparam logic [POS_W-1:0] POS_ZERO_SLOT = 6'h12;
  localparam logic [POS_W-1:0] POS_CH0_EXT_TEMP_LO = 6'h07;
  localparam logic [POS_W-1:0] POS_CH0_EXT_TEMP_HI = 6'h08;
  localparam logic [POS_W-1:0] POS_CH0_TEMP_STATUS = 6'h09;
  localparam logic [POS_W-1:0] POS_CH0_VENDOR_STATUS = 6'h05;
  localparam logic [POS_W-1:0] POS_CH0_OUTPUT_POWER_LO = 6'h0d;
  typedef enum logic [0:0] {FLLR_IDLE, FLLR_SEND} fllr_state_t;
endpackage

// ==== logic/fllr_readout.sv ====
// Fault record block read formatter: count, preamble, downward loop walk
// How it works
// - Send count 0xFF, then pointer snapshot first
// - Bytes 55 to 237 carry loop contents
// - Byte 55 is entry at snapshot position
// - Each later byte is next lower position; 0 wraps to 35
// - Loop is 36 bytes; index 18 reads zero
// - Channel 0 status 9, temp high 8, low 7
// - Preamble byte 0 holds pointer at fault
`timescale 1ns/1ps
module fllr_readout
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic START_I,
  input wire logic NEXT_I,
  input wire logic [fllr_pkg::POS_W-1:0] LOOP_PTR_I,
  input wire logic [7:0] PRE_DATA_I,
  input wire logic LOOP_WR_I,
  input wire logic [fllr_pkg::POS_W-1:0] LOOP_WR_POS_I,
  input wire logic [7:0] LOOP_WR_DATA_I,
  output logic [7:0] BYTE_O,
  output logic VALID_O,
  output logic [fllr_pkg::IDX_W-1:0] PRE_IDX_O
);
  import fllr_pkg::*;

  logic [7:0] loop_mem [LOOP_LEN];
  fllr_state_t state_q, state_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [POS_W-1:0] pos_q, pos_d, snap_q, snap_d, pos_dn;
  logic [7:0] byte_q, byte_d, loop_byte;
  logic valid_q, valid_d;
  logic step, in_loop;
  logic [IDX_W-1:0] loop_cnt_q, loop_cnt_d;

  localparam logic [IDX_W-1:0] LOOP_BYTES = IDX_LOOP_LAST - IDX_LOOP_FIRST + 8'h01;

  // Refuse constant sets that the fixed byte-wide datapath cannot serve
  if (LOOP_LEN != POS_TOP + 1) begin : g_len_check
    $error("loop length and top position disagree");
  end
  if ($bits({2'b00, POS_TOP}) != $bits(BYTE_COUNT) ||
      IDX_W != $bits(BYTE_COUNT)) begin : g_width_check
    $error("position or index width does not fit a byte");
  end
  if (POS_ZERO_SLOT > POS_TOP || IDX_LOOP_FIRST > IDX_LOOP_LAST) begin : g_range_check
    $error("zero slot or loop byte range out of order");
  end

  // Capture side fills one loop by position; ch0 fields land at 9/8/7
  always_ff @(posedge CLK_SYS_I) begin
    if (LOOP_WR_I && LOOP_WR_POS_I <= POS_TOP) begin
      loop_mem[LOOP_WR_POS_I] <= LOOP_WR_DATA_I;
    end
  end

  assign step = (state_q == FLLR_SEND) && NEXT_I;
  assign in_loop = (idx_q >= IDX_LOOP_FIRST) && (idx_q <= IDX_LOOP_LAST);
  assign pos_dn = (pos_q == POS_BOTTOM || pos_q > POS_TOP) ? POS_TOP : pos_q - 6'h01;

  always_comb begin
    if (pos_q == POS_ZERO_SLOT || pos_q > POS_TOP) begin
      loop_byte = ZERO_BYTE;
    end else begin
      loop_byte = loop_mem[pos_q];
    end
  end

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    pos_d = pos_q;
    snap_d = snap_q;
    byte_d = byte_q;
    valid_d = valid_q;
    case (state_q)
      FLLR_IDLE: begin
        if (START_I) begin
          snap_d = LOOP_PTR_I;
          pos_d = LOOP_PTR_I;
          byte_d = BYTE_COUNT;
          valid_d = 1'b1;
          idx_d = IDX_PTR;
          state_d = FLLR_SEND;
        end
      end
      FLLR_SEND: begin
        if (NEXT_I) begin
          if (idx_q == IDX_END) begin
            valid_d = 1'b0;
            byte_d = ZERO_BYTE;
            state_d = FLLR_IDLE;
          end else begin
            idx_d = idx_q + 8'h01;
            if (idx_q == IDX_PTR) begin
              byte_d = {2'b00, snap_q};
            end else if (idx_q == IDX_RSVD) begin
              byte_d = ZERO_BYTE;
            end else if (idx_q < IDX_LOOP_FIRST) begin
              byte_d = PRE_DATA_I;
            end else if (in_loop) begin
              byte_d = loop_byte;
              pos_d = pos_dn;
            end else begin
              byte_d = ZERO_BYTE;
            end
          end
        end
      end
      default: state_d = FLLR_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      state_q <= FLLR_IDLE;
      idx_q <= IDX_PTR;
      pos_q <= POS_BOTTOM;
      snap_q <= POS_BOTTOM;
      byte_q <= ZERO_BYTE;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      pos_q <= pos_d;
      snap_q <= snap_d;
      byte_q <= byte_d;
      valid_q <= valid_d;
    end
  end

  // Tally of loop bytes sent in the current read, for the length check
  always_comb begin
    loop_cnt_d = loop_cnt_q;
    if (state_q == FLLR_IDLE && START_I) begin
      loop_cnt_d = 8'h00;
    end else if (step && in_loop) begin
      loop_cnt_d = loop_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      loop_cnt_q <= 8'h00;
    end else begin
      loop_cnt_q <= loop_cnt_d;
    end
  end

  // Preamble source is addressed one byte ahead of the consume strobe
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      PRE_IDX_O <= IDX_PTR;
    end else begin
      PRE_IDX_O <= idx_d;
    end
  end

  assign BYTE_O = byte_q;
  assign VALID_O = valid_q;

  chk_count_first: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_q == FLLR_IDLE && START_I) |=> (BYTE_O == BYTE_COUNT && VALID_O))
    else $error("count byte not first");
  chk_ptr_first: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && idx_q == IDX_PTR) |=> (BYTE_O == {2'b00, $past(snap_q)}))
    else $error("pointer snapshot not first data byte");
  chk_loop_start: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && idx_q == IDX_LOOP_FIRST) |-> (pos_q == snap_q))
    else $error("loop walk does not start at snapshot");
  chk_walk_down: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && in_loop && pos_q != POS_BOTTOM && pos_q <= POS_TOP)
    |=> (pos_q == $past(pos_q) - 6'h01))
    else $error("loop position not decremented");
  chk_loop_wrap: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && in_loop && pos_q == POS_BOTTOM) |=> (pos_q == POS_TOP))
    else $error("loop position did not wrap");
  chk_zero_slot: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && in_loop && pos_q == POS_ZERO_SLOT) |=> (BYTE_O == ZERO_BYTE))
    else $error("index 18 not zero");
  chk_loop_data: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && in_loop) |=> (BYTE_O == $past(loop_byte) && VALID_O))
    else $error("loop byte mismatch");
  chk_tail_zero: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && idx_q > IDX_LOOP_LAST && idx_q <= IDX_LAST) |=> (BYTE_O == ZERO_BYTE))
    else $error("reserved tail not zero");
  chk_stream_end: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && idx_q == IDX_END)
    |=> ((!VALID_O && BYTE_O == ZERO_BYTE) ##1 (!VALID_O || $past(START_I))))
    else $error("stream did not end after byte 254");

  // Start and consume handshake checks
  chk_ptr_capture: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_q == FLLR_IDLE && START_I) |=> (snap_q == $past(LOOP_PTR_I)))
    else $error("loop pointer not captured at start");
  chk_busy_start: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_q == FLLR_SEND && START_I && !NEXT_I) |=> ($stable(BYTE_O) && VALID_O))
    else $error("start while busy disturbed the read");
  chk_idle_quiet: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_q == FLLR_IDLE && !START_I) |=> (!VALID_O && BYTE_O == ZERO_BYTE))
    else $error("byte offered without a start");

  // Byte placement checks
  chk_pre_index: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_q == FLLR_SEND) |-> (PRE_IDX_O == idx_q))
    else $error("preamble index out of step");
  chk_rsvd_byte: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && idx_q == IDX_RSVD) |=> (BYTE_O == ZERO_BYTE))
    else $error("reserved data byte not zero");
  chk_pre_data: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && idx_q > IDX_RSVD && idx_q < IDX_LOOP_FIRST) |=> (BYTE_O == $past(PRE_DATA_I)))
    else $error("preamble byte not passed through");
  chk_ch0_status: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && in_loop && pos_q == POS_CH0_TEMP_STATUS)
    |=> (BYTE_O == loop_mem[POS_CH0_TEMP_STATUS] && pos_q == POS_CH0_EXT_TEMP_HI))
    else $error("channel 0 status not followed by temperature high");
  chk_ch0_temp: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && in_loop && pos_q == POS_CH0_EXT_TEMP_HI)
    |=> (BYTE_O == loop_mem[POS_CH0_EXT_TEMP_HI] && pos_q == POS_CH0_EXT_TEMP_LO))
    else $error("channel 0 temperature high not followed by low");
  chk_loop_count: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (step && idx_q == IDX_END) |-> (loop_cnt_q == LOOP_BYTES))
    else $error("wrong number of loop bytes in read");
endmodule

// ==== tb/fllr_host.sv ====
// Host model: starts block reads and takes bytes with random stalls
`timescale 1ns/1ps
module fllr_host (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic valid_i,
  input wire logic [7:0] byte_i,
  output logic start_o,
  output logic next_o,
  output logic got_o,
  output logic [7:0] got_byte_o
);
  initial begin
    start_o = 1'b0;
    next_o = 1'b0;
    got_o = 1'b0;
    got_byte_o = 8'h00;
  end
  always @(negedge clk_i) begin
    // Stray starts while busy and consumes while idle must both be ignored
    start_o <= (go_i && !valid_i && !start_o) || (valid_i && $urandom_range(15) == 0);
    next_o <= ($urandom_range(3) != 0);
  end
  always @(posedge clk_i) begin
    got_o <= next_o && valid_i;
    got_byte_o <= byte_i;
  end
endmodule

// ==== tb/test_fllr_readout.sv ====
// Bench for the fault record loop readout formatter
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h seen %h", n, e, s); end end
module test_fllr_readout;
  import fllr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, wr = 1'b0, start, next, valid, got;
  logic [POS_W-1:0] ptr = 6'h00, wpos = 6'h00;
  logic [7:0] wdata = 8'h00, key = 8'h00, byt, gotb, pre;
  logic [IDX_W-1:0] pidx;
  logic [7:0] loop_m [36];
  logic [7:0] expq [$];
  int miscompares = 0, n_compared = 0, cycles = 0, k = 0;
  int ptrs [4] = '{0, 35, 9, 17};
  assign pre = pidx ^ key;
  always #20 clk = ~clk;
  fllr_readout u_dut (.CLK_SYS_I(clk), .RESET_I(rst), .START_I(start), .NEXT_I(next),
    .LOOP_PTR_I(ptr), .PRE_DATA_I(pre), .LOOP_WR_I(wr), .LOOP_WR_POS_I(wpos),
    .LOOP_WR_DATA_I(wdata), .BYTE_O(byt), .VALID_O(valid), .PRE_IDX_O(pidx));
  fllr_host u_host (.clk_i(clk), .go_i(go), .valid_i(valid), .byte_i(byt),
    .start_o(start), .next_o(next), .got_o(got), .got_byte_o(gotb));
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end
  always @(negedge clk) if (got === 1'b1) begin
    if (k == 0) `CHK("count", expq[k], gotb)
    else if (k == 1) `CHK("pointer", expq[k], gotb)
    else if (k > 55 && k < 239) `CHK("loop", expq[k], gotb)
    else `CHK("preamble", expq[k], gotb)
    k++;
  end
  task automatic run(input int p);
    int pos;
    ptr = POS_W'(p);
    key = 8'($urandom);
    k = 0;
    expq.delete();
    expq.push_back(BYTE_COUNT);
    expq.push_back(8'(p));
    expq.push_back(ZERO_BYTE);
    for (int d = 2; d < 55; d++) expq.push_back(8'(d) ^ key);
    pos = p;
    for (int d = 55; d < 238; d++) begin
      expq.push_back(loop_m[pos]);
      pos = (pos == 0) ? 35 : pos - 1;
    end
    for (int d = 238; d < 255; d++) expq.push_back(ZERO_BYTE);
    go = 1'b1;
    wait (valid === 1'b1);
    @(negedge clk);
    go = 1'b0;
    wait (valid === 1'b0);
    repeat (2) @(negedge clk);
    `CHK("length", 256, k)
    $display("test pointer %0d done", p);
  endtask
  initial begin
    void'($urandom(37645));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 36; p++) begin
      wr = 1'b1;
      wpos = POS_W'(p);
      wdata = 8'($urandom) | 8'h01;
      loop_m[p] = (p == 18) ? ZERO_BYTE : wdata;
      @(negedge clk);
    end
    wr = 1'b0;
    foreach (ptrs[i]) run(ptrs[i]);
    test_done();
  end
endmodule
